// ===== rtl/cfglc_pkg.sv
// Package for the configurable logic cell: register map, field layout,
// reset values, source pool layout and the function codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package cfglc_pkg;

    // ==========================================================
    // Register map
    localparam int           ADDR_W        = 8;
    localparam logic [7:0]   ADDR_CTRL_LOW  = 8'h00;
    localparam logic [7:0]   ADDR_CTRL_HIGH = 8'h04;
    localparam logic [7:0]   ADDR_MUX_SEL   = 8'h08;
    localparam logic [7:0]   ADDR_GATE_LOW  = 8'h0C;
    localparam logic [7:0]   ADDR_GATE_HIGH = 8'h10;
    localparam logic [15:0]  REG_RST        = 16'h0000;

    // ==========================================================
    // Field positions and writable masks
    localparam int           EN_BIT        = 15;
    localparam int           RISE_IRQ_BIT  = 11;
    localparam int           FALL_IRQ_BIT  = 10;
    localparam int           PIN_OE_BIT    = 7;
    localparam int           STATUS_BIT    = 6;
    localparam int           INVERT_BIT    = 5;
    localparam int           MODE_LSB      = 0;
    localparam int           MUX_SEL_W     = 4;
    localparam logic [15:0]  CTRL_LOW_MASK  = 16'h8CA7;
    localparam logic [15:0]  CTRL_HIGH_MASK = 16'h000F;
    localparam logic [15:0]  MUX_SEL_MASK   = 16'h7777;
    localparam logic [15:0]  GATE_MASK      = 16'hFFFF;

    // ==========================================================
    // Source pool: 8 inputs per multiplexer, 32 in total
    localparam int           N_MUX         = 4;
    localparam int           N_SRC         = 8;
    // Code that carries the external pin for each multiplexer
    localparam logic [2:0]   PIN_SLOT [N_MUX] = '{3'h0, 3'h0, 3'h0, 3'h5};
    // Reserved codes read as a constant zero source
    localparam logic [7:0]   RSVD_MASK [N_MUX] = '{8'h20, 8'h32, 8'h00, 8'h10};

    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;

    // ==========================================================
    // Function codes
    typedef enum logic [2:0] {
        MODE_AND_OR  = 3'h0,
        MODE_OR_XOR  = 3'h1,
        MODE_AND4    = 3'h2,
        MODE_SR      = 3'h3,
        MODE_DFF_SR  = 3'h4,
        MODE_DFF2_R  = 3'h5,
        MODE_JK_R    = 3'h6,
        MODE_LATCH   = 3'h7
    } cfglc_mode_t;

    // Control fields decoded from the low control register
    typedef struct packed {
        logic        en;
        logic        rise_irq;
        logic        fall_irq;
        logic        pin_oe;
        logic        invert;
        cfglc_mode_t mode;
    } cfglc_ctrl_t;

endpackage

// ===== rtl/cfglc_top.sv
// Configurable logic cell with an AXI4-Lite register slave.
// Assumes pins arrive asynchronously; on-chip sources share CLK_SYS.
// Operation
// R1 - Enable combines inputs through the function; disabled output is zero
// R2 - Rising-edge enable requests an interrupt when output goes low to high
// R3 - Falling-edge enable requests an interrupt when output goes high to low
// R4 - Result drives the port pin only while pin output enable is set
// R5 - Read-only status bit shows current cell output level
// R6 - Output invert bit inverts the function result
// R7 - Codes 000, 001, 010 give AND-OR, OR-XOR, four-input AND
// R8 - Codes 011, 100, 101 give SR latch, D flip-flop S/R, two-input D
// R9 - Code 110 gives JK with reset, 111 a transparent latch with S/R
// R10 - Four gates fed from 32 signals through four selection multiplexers
// R11 - Each mux gives true and inverted copies; gates OR enabled ones
// R12 - Gate with nothing enabled feeds constant set by its invert bit
// R13 - Each gate invert bit inverts that gate before the function
// R14 - First mux: pin A, instr clock, cell 3, RC clock, ref clock, timers
// R15 - Second mux: pin B, comparator 1, serial transmit, timer compares
// R16 - Third mux: pin C, cell 1, comparator 2, SPI out, receive, cell 4
// R17 - Fourth mux: PWM event, cell 2, comparator 3, SPI in, pin D, timers
// R18 - Software uses SPI sources only when SPI goes through pin select
// R19 - Unimplemented bits ignore writes and read zero
// R20 - All implemented control bits clear to zero at reset
// R21 - Separate true and negated enables admit each mux into each gate
// R22 - Edge detect and sequential modes run on system clock; disable clears
// R23 - Sequential modes: gate 1 clock, 2 data, 3 reset, 4 set; logic uses this layout only for codes 100 and 111 (gate 1 as latch enable)
module cfglc_top
    import cfglc_pkg::*;
(
    input  wire  logic                CLK_SYS,      // System clock, 200 MHz
    input  wire  logic                SYS_RST,      // Async reset, active high
    input  wire  logic [ADDR_W-1:0]   AWADDR,       // Write address
    input  wire  logic                AWVALID,      // Write address valid
    output logic                      AWREADY,      // Write address ready
    input  wire  logic [31:0]         WDATA,        // Write data
    input  wire  logic [3:0]          WSTRB,        // Write byte strobes
    input  wire  logic                WVALID,       // Write data valid
    output logic                      WREADY,       // Write data ready
    output logic [1:0]                BRESP,        // Write response
    output logic                      BVALID,       // Write response valid
    input  wire  logic                BREADY,       // Write response ready
    input  wire  logic [ADDR_W-1:0]   ARADDR,       // Read address
    input  wire  logic                ARVALID,      // Read address valid
    output logic                      ARREADY,      // Read address ready
    output logic [31:0]               RDATA,        // Read data
    output logic [1:0]                RRESP,        // Read response
    output logic                      RVALID,       // Read data valid
    input  wire  logic                RREADY,       // Read data ready
    input  wire  logic [31:0]         SRC_ONCHIP,   // On-chip source pool
    input  wire  logic [3:0]          PIN_IN,       // Pin inputs A..D
    output logic                      CELL_OUT,     // Cell output to peripherals
    output logic                      PIN_OUT,      // Port pin data
    output logic                      PIN_OE,       // Port pin output enable
    output logic                      IRQ_REQ       // Edge interrupt pulse
);

    // ==========================================================
    // Register storage
    logic [15:0]      ctrl_low_q;
    logic [15:0]      ctrl_high_q;
    logic [15:0]      mux_sel_q;
    logic [15:0]      gate_low_q;
    logic [15:0]      gate_high_q;
    cfglc_ctrl_t      ctrl;
    logic             cell_out_q;

    assign ctrl.en       = ctrl_low_q[EN_BIT];
    assign ctrl.rise_irq = ctrl_low_q[RISE_IRQ_BIT];
    assign ctrl.fall_irq = ctrl_low_q[FALL_IRQ_BIT];
    assign ctrl.pin_oe   = ctrl_low_q[PIN_OE_BIT];
    assign ctrl.invert   = ctrl_low_q[INVERT_BIT];
    assign ctrl.mode     = cfglc_mode_t'(ctrl_low_q[MODE_LSB+:3]);

    // ==========================================================
    // AXI4-Lite write channel
    logic             aw_hold_q;
    logic             w_hold_q;
    logic [7:0]       waddr_q;
    logic [15:0]      wdata_q;
    logic [1:0]       wstrb_q;
    logic             aw_fire;
    logic             w_fire;
    logic             do_wr;
    logic             wr_hit;

    assign aw_fire = AWVALID && AWREADY;
    assign w_fire  = WVALID && WREADY;
    // Both halves held in registers; slave takes them in either order
    assign do_wr   = aw_hold_q && w_hold_q && !BVALID;
    assign wr_hit  = (waddr_q == ADDR_CTRL_LOW) || (waddr_q == ADDR_CTRL_HIGH) ||
                     (waddr_q == ADDR_MUX_SEL) || (waddr_q == ADDR_GATE_LOW) ||
                     (waddr_q == ADDR_GATE_HIGH);

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'h0;
            AWREADY   <= 1'b1;
            WREADY    <= 1'b1;
            BVALID    <= 1'b0;
            BRESP     <= RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_hold_q <= 1'b1;
                AWREADY   <= 1'b0;
                waddr_q   <= AWADDR;
            end
            if (w_fire) begin
                w_hold_q <= 1'b1;
                WREADY   <= 1'b0;
                wdata_q  <= WDATA[15:0];
                wstrb_q  <= WSTRB[1:0];
            end
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                BVALID    <= 1'b1;
                BRESP     <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            // Next address is accepted only after the response is gone
            if (BVALID && BREADY) begin
                BVALID  <= 1'b0;
                AWREADY <= 1'b1;
                WREADY  <= 1'b1;
            end
        end
    end

    // Merge write data into a register under strobe and implemented mask
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] mask);
        logic [15:0] m;
        m = mask & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        return (old & ~m) | (wdata_q & m);
    endfunction

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_low_q  <= REG_RST; // R20
            ctrl_high_q <= REG_RST;
            mux_sel_q   <= REG_RST;
            gate_low_q  <= REG_RST;
            gate_high_q <= REG_RST;
        end else if (do_wr) begin
            // Masks keep unimplemented and status bits at zero
            case (waddr_q)
                ADDR_CTRL_LOW:  ctrl_low_q  <= merge(ctrl_low_q, CTRL_LOW_MASK); // R19
                ADDR_CTRL_HIGH: ctrl_high_q <= merge(ctrl_high_q, CTRL_HIGH_MASK);
                ADDR_MUX_SEL:   mux_sel_q   <= merge(mux_sel_q, MUX_SEL_MASK);
                ADDR_GATE_LOW:  gate_low_q  <= merge(gate_low_q, GATE_MASK);
                ADDR_GATE_HIGH: gate_high_q <= merge(gate_high_q, GATE_MASK);
                default: ;
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    logic [15:0]      rd_val;
    logic             rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        case (ARADDR)
            ADDR_CTRL_LOW: begin
                rd_val = ctrl_low_q;
                rd_val[STATUS_BIT] = cell_out_q; // R5
            end
            ADDR_CTRL_HIGH: rd_val = ctrl_high_q;
            ADDR_MUX_SEL:   rd_val = mux_sel_q;
            ADDR_GATE_LOW:  rd_val = gate_low_q;
            ADDR_GATE_HIGH: rd_val = gate_high_q;
            default: begin
                rd_val = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ARREADY <= 1'b1;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RDATA   <= {16'h0000, rd_val}; // R19
            RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID  <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // ==========================================================
    // Pin synchroniser: a change counts once stages two and three agree
    logic [3:0]       pin_s1_q;
    logic [3:0]       pin_s2_q;
    logic [3:0]       pin_s3_q;
    logic [3:0]       pin_f_q;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
            pin_f_q  <= 4'h0;
        end else begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // Per pin, so one pin in motion never holds back another
            pin_f_q  <= (pin_f_q & (pin_s2_q ^ pin_s3_q)) | (pin_s3_q & ~(pin_s2_q ^ pin_s3_q));
        end
    end

    // ==========================================================
    // Selection multiplexers and input gates
    logic [N_MUX-1:0] mux_v;
    logic [3:0]       gate_v;
    logic [3:0]       gate_or;
    logic [7:0]       gate_sel [4];

    // OR of every true or negated mux copy enabled in this selection byte
    function automatic logic gate_sum(input logic [7:0] sel, input logic [3:0] mv);
        logic acc;
        acc = 1'b0;
        for (int m = 0; m < N_MUX; m++) begin
            acc = acc | (sel[2*m+1] & mv[m]) | (sel[2*m] & ~mv[m]); // R21
        end
        return acc;
    endfunction

    for (genvar i = 0; i < N_MUX; i++) begin : g_mux
        logic [2:0] code;
        logic [7:0] pool;
        assign code = mux_sel_q[MUX_SEL_W*i+:3];
        // Pin slot replaced by its synchronised level, reserved codes give zero
        always_comb begin
            pool = SRC_ONCHIP[N_SRC*i+:N_SRC] & ~RSVD_MASK[i];
            pool[PIN_SLOT[i]] = pin_f_q[i];
        end
        assign mux_v[i] = pool[code]; // R10 R14 R15 R16 R17

        assign gate_sel[i] = (i < 2) ? gate_low_q[8*(i%2)+:8] : gate_high_q[8*(i%2)+:8];
        assign gate_or[i]  = gate_sum(gate_sel[i], mux_v); // R11
        // Nothing enabled leaves the OR at zero, so the invert bit sets the level
        assign gate_v[i]   = gate_or[i] ^ ctrl_high_q[i]; // R12 R13
    end

    // ==========================================================
    // Logic function
    logic             seq_q;
    logic             clk_prev_q;
    logic             clk_rise;
    logic             func_v;
    logic             cell_out_d;

    // Gate 1 is sampled on CLK_SYS, so its edges must be slower than half the clock
    assign clk_rise = gate_v[0] && !clk_prev_q;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            seq_q      <= 1'b0;
            clk_prev_q <= 1'b0;
        end else if (!ctrl.en) begin
            seq_q      <= 1'b0; // R22
            // Track gate 1 while off, so enabling never sees a false clock edge
            clk_prev_q <= gate_v[0];
        end else begin
            clk_prev_q <= gate_v[0];
            case (ctrl.mode)
                MODE_SR: begin
                    if (gate_v[0] || gate_v[1]) seq_q <= 1'b1; // R8
                    else if (gate_v[2] || gate_v[3]) seq_q <= 1'b0;
                end
                MODE_DFF_SR: begin
                    if (gate_v[2]) seq_q <= 1'b0; // R23
                    else if (gate_v[3]) seq_q <= 1'b1;
                    else if (clk_rise) seq_q <= gate_v[1]; // R8
                end
                MODE_DFF2_R: begin
                    if (gate_v[2]) seq_q <= 1'b0;
                    else if (clk_rise) seq_q <= gate_v[1] & gate_v[3]; // R8
                end
                MODE_JK_R: begin
                    if (gate_v[2]) seq_q <= 1'b0;
                    else if (clk_rise) seq_q <= (gate_v[1] & ~seq_q) | (~gate_v[3] & seq_q); // R9
                end
                MODE_LATCH: begin
                    if (gate_v[2]) seq_q <= 1'b0;
                    else if (gate_v[3]) seq_q <= 1'b1;
                    else if (gate_v[0]) seq_q <= gate_v[1]; // R9
                end
                default: seq_q <= 1'b0;
            endcase
        end
    end

    always_comb begin
        case (ctrl.mode)
            MODE_AND_OR: func_v = (gate_v[0] & gate_v[1]) | (gate_v[2] & gate_v[3]); // R7
            MODE_OR_XOR: func_v = (gate_v[0] | gate_v[1]) ^ (gate_v[2] | gate_v[3]);
            MODE_AND4:   func_v = &gate_v;
            default:     func_v = seq_q;
        endcase
        cell_out_d = ctrl.en ? (func_v ^ ctrl.invert) : 1'b0; // R1 R6
    end

    // ==========================================================
    // Output, pin path and edge interrupts
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            cell_out_q <= 1'b0;
            CELL_OUT   <= 1'b0;
            PIN_OUT    <= 1'b0;
            PIN_OE     <= 1'b0;
            IRQ_REQ    <= 1'b0;
        end else begin
            cell_out_q <= cell_out_d;
            CELL_OUT   <= cell_out_d;
            PIN_OUT    <= cell_out_d & ctrl.pin_oe; // R4
            PIN_OE     <= ctrl.pin_oe;
            IRQ_REQ    <= (ctrl.rise_irq & cell_out_d & ~cell_out_q) | // R2
                          (ctrl.fall_irq & ~cell_out_d & cell_out_q);  // R3
        end
    end

    // ==========================================================
    // Assertions
    disabled_out_zero_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R1
        !ctrl.en |=> !cell_out_q && !CELL_OUT)
        else $error("cell output not zero while disabled");

    rise_irq_pulse_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R2
        ($rose(cell_out_q) && $past(ctrl.rise_irq)) |-> IRQ_REQ)
        else $error("rising edge gave no interrupt request");

    fall_irq_pulse_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R3
        ($fell(cell_out_q) && $past(ctrl.fall_irq)) |-> IRQ_REQ)
        else $error("falling edge gave no interrupt request");

    pin_path_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R4
        !ctrl.pin_oe |=> !PIN_OE && !PIN_OUT)
        else $error("pin driven without output enable");

    status_read_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R5
        (ARVALID && ARREADY && ARADDR == ADDR_CTRL_LOW)
        |=> RVALID && RDATA[STATUS_BIT] == $past(cell_out_q))
        else $error("status bit does not show cell output");

    invert_and4_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R6
        (ctrl.en && ctrl.mode == MODE_AND4) |=> cell_out_q == $past((&gate_v) ^ ctrl.invert))
        else $error("output invert not applied to function");

    and_or_func_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R7
        (ctrl.en && !ctrl.invert && ctrl.mode == MODE_AND_OR)
        |=> cell_out_q == $past((gate_v[0] & gate_v[1]) | (gate_v[2] & gate_v[3])))
        else $error("AND-OR function wrong");

    empty_gate_level_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R12
        (gate_low_q[7:0] == 8'h00) |-> gate_v[0] == ctrl_high_q[0])
        else $error("empty gate does not follow invert bit");

    unimpl_zero_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R19
        (ARVALID && ARREADY && ARADDR == ADDR_MUX_SEL) |=> RDATA[31:0] == {16'h0000,
        $past(mux_sel_q) & MUX_SEL_MASK})
        else $error("unimplemented select bits read nonzero");

    seq_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // R22
        (!ctrl.en ##1 !ctrl.en) |-> !seq_q && clk_prev_q == $past(gate_v[0]))
        else $error("sequential state not cleared while disabled");

endmodule // cfglc_top

// ===== test/cfglc_peer.sv
// Far-side model: on-chip sources and pins that feed the cell.
// Assumes the bench sets the wanted levels between configurations.
module cfglc_peer (
    input  wire logic        clk,      // System clock
    input  wire logic [31:0] src_lvl,  // Wanted on-chip levels
    input  wire logic [3:0]  pin_lvl,  // Wanted pin levels
    output logic      [31:0] src_q,    // Source pool to the cell
    output logic      [3:0]  pin_q     // Pins to the cell
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources launch on the system clock like real on-chip logic
    always_ff @(posedge clk) begin
        src_q <= src_lvl;
        pin_q <= pin_lvl;
    end
endmodule // cfglc_peer

// ===== test/cfglc_top_bench.sv
// Self-checking bench for the configurable logic cell.
// Assumes the register slave answers within a few cycles.
module cfglc_top_bench import cfglc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // Signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = '0;
    logic [7:0]  araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] src = '0;
    logic [3:0]  pin = '0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, cout, pout, poe, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, src_p;
    wire  [3:0]  pin_p;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          irqs = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqs++;

    cfglc_peer u_cfglc_peer (.clk(clk), .src_lvl(src), .pin_lvl(pin), .src_q(src_p),
        .pin_q(pin_p));
    cfglc_top u_cfglc_top (.CLK_SYS(clk), .SYS_RST(rst), .AWADDR(awaddr),
        .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'h3),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
        .SRC_ONCHIP(src_p), .PIN_IN(pin_p), .CELL_OUT(cout), .PIN_OUT(pout),
        .PIN_OE(poe), .IRQ_REQ(irq));

    // ====
    // Bus and check helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        bit aw, w, b;
        aw = 0; w = 0; b = 0; r = 2'h3;
        awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (aw && w && bvalid === 1'b1) begin b = 1; r = bresp; end
            if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
            if (!w && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
        end
        if (!b) bad_count++;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar, b;
        ar = 0; b = 0; d = '1; r = 2'h3;
        araddr <= a; arvalid <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (ar && rvalid === 1'b1) begin b = 1; d = rdata; r = rresp; end
            if (!ar && arready === 1'b1) begin ar = 1; arvalid <= 1'b0; end
        end
        if (!b) bad_count++;
    endtask

    // Covers config latency plus the pin synchroniser
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic step(input logic [7:0] a, input logic [15:0] d, input logic e);
        logic [1:0] r;
        wr(a, d, r);
        settle();
        chk("seq out", cout, e);
    endtask

    // ====
    // Scenarios
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  ad [5] = '{ADDR_CTRL_LOW, ADDR_CTRL_HIGH, ADDR_MUX_SEL,
                                ADDR_GATE_LOW, ADDR_GATE_HIGH};
        logic [15:0] mk [5] = '{CTRL_LOW_MASK, CTRL_HIGH_MASK, MUX_SEL_MASK,
                                GATE_MASK, GATE_MASK};
        logic [15:0] wv;
        for (int i = 0; i < 5; i++) begin
            // Keep the cell off so the status bit stays low
            wv = (i == 0) ? 16'h7FFF : 16'hFFFF;
            rd(ad[i], d, r);
            chk("reset value", d, 32'h0);
            chk("rresp mapped", 32'(r), 32'(RESP_OKAY));
            wr(ad[i], wv, r);
            rd(ad[i], d, r);
            chk("write mask", d, {16'h0000, wv & mk[i]});
            wr(ad[i], 16'h0000, r);
        end
        wr(8'h14, 16'hFFFF, r);
        chk("bresp unmapped", 32'(r), 32'(RESP_SLVERR));
        rd(8'h14, d, r);
        chk("rresp unmapped", 32'(r), 32'(RESP_SLVERR));
        chk("rdata unmapped", d, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_comb();
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  g;
        logic        e;
        // Gates have no source enabled, so each equals its invert bit
        for (int m = 0; m < 3; m++) begin
            for (int p = 0; p < 32; p++) begin
                g = 4'(p);
                case (m)
                    0: e = (g[0] & g[1]) | (g[2] & g[3]);
                    1: e = (g[0] | g[1]) ^ (g[2] | g[3]);
                    default: e = &g;
                endcase
                e = e ^ p[4];
                wr(ADDR_CTRL_HIGH, {12'h000, g}, r);
                wr(ADDR_CTRL_LOW, 16'h8080 | (16'(p[4]) << INVERT_BIT) | 16'(m), r);
                settle();
                chk("comb out", cout, e);
                chk("pin out", pout, e);
                chk("pin oe on", poe, 1'b1);
                rd(ADDR_CTRL_LOW, d, r);
                chk("status", d[STATUS_BIT], e);
            end
        end
        wr(ADDR_CTRL_LOW, 16'h8002, r);
        settle();
        chk("pin oe off", poe, 1'b0);
        chk("cell on", cout, 1'b1);
        wr(ADDR_CTRL_LOW, 16'h0002, r);
        settle();
        chk("cell off", cout, 1'b0);
        $display("test comb done");
    endtask

    task automatic t_mux();
        logic [1:0] r;
        logic       v;
        wr(ADDR_CTRL_HIGH, 16'h000E, r);
        wr(ADDR_CTRL_LOW, 16'h8002, r);
        // Pass 0 uses true enables, pass 1 the negated ones
        for (int s = 0; s < 2; s++) begin
            pin <= (s == 0) ? 4'h0 : 4'hF;
            for (int m = 0; m < 4; m++) begin
                for (int c = 0; c < 8; c++) begin
                    // Only the selected source differs, so a wrong code shows up
                    src <= (32'h1 << (8 * m + c)) ^ ((s == 0) ? 32'h0 : 32'hFFFF_FFFF);
                    v = (3'(c) == PIN_SLOT[m]) ? s[0] : (!RSVD_MASK[m][c] && s == 0);
                    wr(ADDR_MUX_SEL, 16'(c) << (4 * m), r);
                    wr(ADDR_GATE_LOW, 16'h0001 << (2 * m + 1 - s), r);
                    settle();
                    chk("mux path", cout, v ^ s[0]);
                end
            end
        end
        $display("test mux done");
    endtask

    task automatic t_seq();
        logic [1:0] r;
        int         base;
        wr(ADDR_GATE_LOW, 16'h0000, r);
        wr(ADDR_CTRL_HIGH, 16'h0000, r);
        base = irqs;
        step(ADDR_CTRL_LOW, 16'h8C04, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0002, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0003, 1'b1);
        step(ADDR_CTRL_HIGH, 16'h0002, 1'b1);
        step(ADDR_CTRL_HIGH, 16'h0001, 1'b0);
        chk("irq both edges", irqs - base, 2);
        step(ADDR_CTRL_LOW, 16'h8C06, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0002, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0003, 1'b1);
        step(ADDR_CTRL_LOW, 16'h0C06, 1'b0);
        chk("irq disable fall", irqs - base, 4);
        step(ADDR_CTRL_HIGH, 16'h0000, 1'b0);
        step(ADDR_CTRL_LOW, 16'h8006, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0002, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h0003, 1'b1);
        chk("irq masked", irqs - base, 4);
        step(ADDR_CTRL_LOW, 16'h8007, 1'b1);
        step(ADDR_CTRL_HIGH, 16'h0001, 1'b0);
        step(ADDR_CTRL_LOW, 16'h8003, 1'b1);
        step(ADDR_CTRL_HIGH, 16'h0004, 1'b0);
        step(ADDR_CTRL_LOW, 16'h8005, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h000A, 1'b0);
        step(ADDR_CTRL_HIGH, 16'h000B, 1'b1);
        $display("test seq done");
    endtask

    // ====
    // Run control
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_comb();
        t_mux();
        t_seq();
        test_done();
    end

    // All tests need about 2800 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule // cfglc_top_bench
